// File: include/tnr_pkg.sv
`default_nettype none
package tnr_pkg;

	// ==========================================================
	// Host register addresses
	localparam logic [2:0] ADR_STATUS = 3'h0;
	localparam logic [2:0] ADR_IMR = 3'h0;
	localparam logic [2:0] ADR_DIAG = 3'h1;
	localparam logic [2:0] ADR_CMD = 3'h1;
	localparam logic [2:0] ADR_PTR_HI = 3'h2;
	localparam logic [2:0] ADR_PTR_LO = 3'h3;
	localparam logic [2:0] ADR_DATA = 3'h4;
	localparam logic [2:0] ADR_SELIDX = 3'h5;
	localparam logic [2:0] ADR_CFG = 3'h6;
	localparam logic [2:0] ADR_SHARED = 3'h7;

	// ==========================================================
	// Targets behind the shared address
	typedef enum logic [2:0]
	{
		SUB_TENT = 3'b000,
		SUB_NODE = 3'b001,
		SUB_LINK = 3'b010,
		SUB_NEXT = 3'b011,
		SUB_EXT = 3'b100
	} tnr_sub_e;

	typedef enum logic [1:0]
	{
		BUS_IDLE = 2'b00,
		BUS_DRIVE = 2'b01
	} tnr_bus_e;

	// ==========================================================
	// Reset values
	localparam logic [7:0] STATUS_RST = 8'h91;
	localparam logic [7:0] DIAG_RST = 8'h00;
	localparam logic [7:0] CFG_RST = 8'h18;
	localparam logic [7:0] IMR_RST = 8'h00;
	localparam logic [7:0] SETUP_RST = 8'h00;
	localparam logic [7:0] ID_RST = 8'h00;
	localparam logic [10:0] PTR_RST = 11'h000;

	// ==========================================================
	// Field positions
	localparam int ST_RI = 7;
	localparam int ST_POR = 4;
	localparam int ST_RECON = 2;
	localparam int ST_TMA = 1;
	localparam int ST_TA = 0;
	localparam int DG_EXCESS_NAK_FLAG = 3;
	localparam int DG_NEWNEXT = 1;
	localparam logic [7:0] DG_READ_CLR = 8'hf4;
	localparam int CFG_RESET = 7;
	localparam int CFG_TXEN = 5;
	localparam int SEL_TWO = 2;
	localparam int PH_RDDATA = 7;
	localparam int PH_AUTOINC = 6;
	localparam logic [7:0] PH_MASK = 8'hc7;
	localparam logic [7:0] SELIDX_MASK = 8'hc7;
	localparam logic [7:0] IMR_MASK = 8'h8f;
	localparam int LK_PMODE = 7;
	localparam int LK_FOURNAK = 6;
	localparam int LK_RCVALL = 4;
	localparam int LK_CKP_HI = 3;
	localparam int LK_CKP_LO = 1;
	localparam int LK_ARB = 0;
	localparam int EX_FASTRD = 7;
	localparam int EX_NEWTIM = 3;
	localparam int EX_IDLEBYP = 2;
	localparam int EX_RTO_HI = 1;
	localparam int EX_RTO_LO = 0;

	// ==========================================================
	// Command codes
	localparam logic [7:0] CMD_CLR_FLAGS = 8'h0e;
	localparam logic [7:0] CMD_CLR_EXCESS_NAK_FLAG = 8'h16;
	localparam logic [2:0] CMD_OP_TXARM = 3'h3;
	localparam logic [2:0] CMD_OP_RXARM = 3'h4;

	// ==========================================================
	// Reconfiguration periods at full rate
	localparam int RECON_MS_00 = 6720;
	localparam int RECON_MS_01 = 1680;
	localparam int RECON_MS_10 = 840;
	localparam int RECON_MS_11 = 420;
	localparam int CLK_KHZ = 40000;

endpackage : tnr_pkg
`default_nettype wire

// File: core/tnr_pin_sync.sv
`default_nettype none
module tnr_pin_sync
#(
	parameter int W = 1,
	parameter logic [W-1:0] RST_VAL = '0
)
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Pins in, synchronised out
	input wire logic [W-1:0] pinIn,
	output logic [W-1:0] syncOut
);

	logic [W-1:0] stage_q;

	// ==========================================================
	// Two flops per bit
	genvar i;
	generate
		for (i = 0; i < W; i++)
		begin : g_bit
			always_ff @(posedge clk or negedge rst_b)
			begin
				if (!rst_b)
				begin
					stage_q[i] <= RST_VAL[i];
					syncOut[i] <= RST_VAL[i];
				end
				else
				begin
					stage_q[i] <= pinIn[i];
					syncOut[i] <= stage_q[i];
				end
			end
		end
	endgenerate

endmodule : tnr_pin_sync
`default_nettype wire

// File: core/tnr_register_bank.sv
// Functional notes
// - Diagnostic read or reset clears most flags
// - Excess NAK cleared only by command/reset
// - Diagnostic reads zero after any reset
// - Command write starts the written command
// - High pointer byte first; low loads
// - Pointer contents undefined until written
// - Config resets to 18h, hardware only
// - Select bits pick shared-address register
// - Low two select bits shared with config
// - Select bit two reaches extended setup
// - Config write clears select bit two
// - Link setup: rate, arbitration, receive-all, pulse
// - Link setup zero on hardware reset only
// - Extended setup fast-read bus enable
// - New-timing enable, zero keeps legacy timing
// - Idle-wait bypass gates init sequence
// - Two-bit field picks reconfiguration period
// - Periods scale with reduced data rate
// - Receiver inhibited set on store, cleared arm
// - Reset flag set by resets, ID zero
// - Test status bit reads zero
// - Masked status and diagnostic flags ORed into interrupt
// - Next-ID read clears next-changed flag
`default_nettype none
module tnr_register_bank
#(
	parameter logic [31:0] RECON_CYC_00 = 32'(tnr_pkg::RECON_MS_00 * tnr_pkg::CLK_KHZ),
	parameter logic [31:0] RECON_CYC_01 = 32'(tnr_pkg::RECON_MS_01 * tnr_pkg::CLK_KHZ),
	parameter logic [31:0] RECON_CYC_10 = 32'(tnr_pkg::RECON_MS_10 * tnr_pkg::CLK_KHZ),
	parameter logic [31:0] RECON_CYC_11 = 32'(tnr_pkg::RECON_MS_11 * tnr_pkg::CLK_KHZ)
)
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Host parallel bus pins
	input wire logic rdStrobe_b,
	input wire logic wrStrobe_b,
	input wire logic [2:0] busAddr,
	input wire logic [7:0] busDataIn,
	output logic [7:0] busDataOut,
	output logic busDataOe,
	// Events from the protocol core
	input wire logic evPacketStored,
	input wire logic evTxDone,
	input wire logic evTxAcked,
	input wire logic evRecon,
	input wire logic evExcessNak,
	input wire logic evNextIdUpdate,
	input wire logic [7:0] newNextId,
	input wire logic [7:0] diagSetIn,
	input wire logic lineIdle,
	// Command and pointer to the core
	output logic [7:0] cmdCode,
	output logic cmdStrobe,
	output logic [10:0] ramAddr,
	output logic ramAddrLoad,
	output logic ramAutoInc,
	output logic ramReadMode,
	// Configuration to the core
	output logic swReset,
	output logic txEnable,
	output logic [7:0] nodeId,
	output logic [7:0] tentId,
	output logic arbSlow,
	output logic [2:0] clkPrescale,
	output logic rcvAll,
	output logic fourNaks,
	output logic pulseDriverOutput,
	output logic fastReadControl,
	output logic newTimingEnable,
	output logic initSeqAllowed,
	output logic [39:0] reconPeriodCyc,
	output logic nakOnRx,
	output logic irq
);

	// ==========================================================
	// Pin synchronisers
	logic rdNow, wrNow, rdPrev_q, wrPrev_q, rdStart, wrTake;
	logic [2:0] sAddr;
	logic [7:0] sData;

	tnr_pin_sync #(.W(13), .RST_VAL(13'h1800)) u_sync
	(
		.clk(clk),
		.rst_b(rst_b),
		.pinIn({rdStrobe_b, wrStrobe_b, busAddr, busDataIn}),
		.syncOut({rdNow, wrNow, sAddr, sData})
	);

	// Write taken on the trailing edge, when data has settled
	assign rdStart = rdPrev_q && !rdNow;
	assign wrTake = !wrPrev_q && wrNow;

	function automatic tnr_pkg::tnr_sub_e subTarget(input logic [2:0] s);
		if (s[tnr_pkg::SEL_TWO])
			return tnr_pkg::SUB_EXT;
		case (s[1:0])
			2'b00: return tnr_pkg::SUB_TENT;
			2'b01: return tnr_pkg::SUB_NODE;
			2'b10: return tnr_pkg::SUB_LINK;
			default: return tnr_pkg::SUB_NEXT;
		endcase
	endfunction : subTarget

	// ==========================================================
	// Register state
	logic ri_q, por_q, recon_q, tma_q, ta_q;
	logic ri_d, por_d, recon_d, tma_d, ta_d;
	logic [7:0] diag_q, diag_d, imr_q, imr_d;
	logic [7:0] ptrHi_q, ptrHi_d, nextId_q, nextId_d;
	logic [7:0] node_q, node_d, tent_q, tent_d, link_q, link_d, ext_q, ext_d;
	logic [7:2] cfgHi_q, cfgHi_d;
	logic [7:6] selHi_q, selHi_d;
	logic [2:0] sel_q, sel_d;
	logic [10:0] ptr_q, ptr_d;
	logic ptrLoad_q, ptrLoad_d, cmdStb_q, cmdStb_d;
	logic [7:0] cmd_q, cmd_d;
	logic irq_q, irq_d, initOk_q, initOk_d;
	logic [39:0] recon_per_q, recon_per_d;
	logic [7:0] statusVal, maskable;
	logic wrCmd, clrFlags, clrExc, rxArm, txArm, rdDiag, rdNext, wrNode;
	logic [31:0] reconBase;
	tnr_pkg::tnr_sub_e tgt;

	// ==========================================================
	// Next values for registers and flags
	always_comb
	begin
		tgt = subTarget(sel_q);
		statusVal = {ri_q, 2'b00, por_q, 1'b0, recon_q, tma_q, ta_q};
		wrCmd = wrTake && sAddr == tnr_pkg::ADR_CMD;
		clrFlags = wrCmd && sData == tnr_pkg::CMD_CLR_FLAGS;
		clrExc = wrCmd && sData == tnr_pkg::CMD_CLR_EXCESS_NAK_FLAG;
		rxArm = wrCmd && sData[2:0] == tnr_pkg::CMD_OP_RXARM;
		txArm = wrCmd && sData[2:0] == tnr_pkg::CMD_OP_TXARM;
		rdDiag = rdStart && sAddr == tnr_pkg::ADR_DIAG;
		rdNext = rdStart && sAddr == tnr_pkg::ADR_SHARED && tgt == tnr_pkg::SUB_NEXT;
		wrNode = wrTake && sAddr == tnr_pkg::ADR_SHARED && tgt == tnr_pkg::SUB_NODE;

		// Commands pass through untouched
		cmdStb_d = wrCmd;
		cmd_d = wrCmd ? sData : cmd_q;

		// Sets win over command and read clears on every flag; software reset overrides both
		ri_d = evPacketStored || (ri_q && !rxArm);
		ta_d = evTxDone || (ta_q && !txArm);
		tma_d = evTxAcked || (tma_q && !txArm);
		recon_d = evRecon || (recon_q && !clrFlags);
		por_d = wrNode && sData == tnr_pkg::ID_RST || (por_q && !clrFlags);
		diag_d = diag_q;
		if (rdDiag)
			diag_d = diag_d & ~tnr_pkg::DG_READ_CLR;
		if (clrExc)
			diag_d[tnr_pkg::DG_EXCESS_NAK_FLAG] = 1'b0;
		if (rdNext)
			diag_d[tnr_pkg::DG_NEWNEXT] = 1'b0;
		diag_d = diag_d | (diagSetIn & tnr_pkg::DG_READ_CLR);
		diag_d[tnr_pkg::DG_EXCESS_NAK_FLAG] = diag_d[tnr_pkg::DG_EXCESS_NAK_FLAG] | evExcessNak;
		diag_d[tnr_pkg::DG_NEWNEXT] = diag_d[tnr_pkg::DG_NEWNEXT] | evNextIdUpdate;
		diag_d[0] = 1'b0;
		nextId_d = evNextIdUpdate ? newNextId : nextId_q;

		// Plain host writes
		imr_d = imr_q;
		ptrHi_d = ptrHi_q;
		ptr_d = ptr_q;
		ptrLoad_d = 1'b0;
		cfgHi_d = cfgHi_q;
		selHi_d = selHi_q;
		sel_d = sel_q;
		tent_d = tent_q;
		node_d = node_q;
		link_d = link_q;
		ext_d = ext_q;
		if (wrTake)
		begin
			case (sAddr)
				tnr_pkg::ADR_IMR: imr_d = sData & tnr_pkg::IMR_MASK;
				tnr_pkg::ADR_PTR_HI: ptrHi_d = sData & tnr_pkg::PH_MASK;
				tnr_pkg::ADR_PTR_LO:
				begin
					ptr_d = {ptrHi_q[2:0], sData};
					ptrLoad_d = 1'b1;
				end
				tnr_pkg::ADR_SELIDX:
				begin
					selHi_d = sData[7:6];
					sel_d = sData[2:0];
				end
				tnr_pkg::ADR_CFG:
				begin
					cfgHi_d = sData[7:2];
					sel_d = {1'b0, sData[1:0]};
				end
				tnr_pkg::ADR_SHARED:
				begin
					case (tgt)
						tnr_pkg::SUB_TENT: tent_d = sData;
						tnr_pkg::SUB_NODE: node_d = sData;
						tnr_pkg::SUB_LINK: link_d = sData;
						tnr_pkg::SUB_EXT: ext_d = sData;
						default: ;
					endcase
				end
				default: ;
			endcase
		end

		// Software reset: flags and next ID only, setup and config survive
		if (cfgHi_q[tnr_pkg::CFG_RESET])
		begin
			ri_d = tnr_pkg::STATUS_RST[tnr_pkg::ST_RI];
			ta_d = tnr_pkg::STATUS_RST[tnr_pkg::ST_TA];
			tma_d = tnr_pkg::STATUS_RST[tnr_pkg::ST_TMA];
			recon_d = tnr_pkg::STATUS_RST[tnr_pkg::ST_RECON];
			por_d = 1'b1;
			diag_d = tnr_pkg::DIAG_RST;
			nextId_d = tnr_pkg::ID_RST;
		end

		maskable = {ri_q, 2'b00, 1'b0, diag_q[tnr_pkg::DG_EXCESS_NAK_FLAG], recon_q,
			diag_q[tnr_pkg::DG_NEWNEXT], ta_q};
		irq_d = |(maskable & imr_q);
		initOk_d = ext_q[tnr_pkg::EX_IDLEBYP] || lineIdle;

		case (ext_q[tnr_pkg::EX_RTO_HI:tnr_pkg::EX_RTO_LO])
			2'b00: reconBase = RECON_CYC_00;
			2'b01: reconBase = RECON_CYC_01;
			2'b10: reconBase = RECON_CYC_10;
			default: reconBase = RECON_CYC_11;
		endcase
		// Each prescale step halves the rate, so the period doubles
		recon_per_d = {8'h00, reconBase} << link_q[tnr_pkg::LK_CKP_HI:tnr_pkg::LK_CKP_LO];
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			ri_q <= tnr_pkg::STATUS_RST[tnr_pkg::ST_RI];
			por_q <= tnr_pkg::STATUS_RST[tnr_pkg::ST_POR];
			recon_q <= tnr_pkg::STATUS_RST[tnr_pkg::ST_RECON];
			tma_q <= tnr_pkg::STATUS_RST[tnr_pkg::ST_TMA];
			ta_q <= tnr_pkg::STATUS_RST[tnr_pkg::ST_TA];
			diag_q <= tnr_pkg::DIAG_RST;
			imr_q <= tnr_pkg::IMR_RST;
			ptrHi_q <= tnr_pkg::SETUP_RST;
			ptr_q <= tnr_pkg::PTR_RST;
			ptrLoad_q <= 1'b0;
			nextId_q <= tnr_pkg::ID_RST;
			node_q <= tnr_pkg::ID_RST;
			tent_q <= tnr_pkg::ID_RST;
			link_q <= tnr_pkg::SETUP_RST;
			ext_q <= tnr_pkg::SETUP_RST;
			cfgHi_q <= tnr_pkg::CFG_RST[7:2];
			sel_q <= {1'b0, tnr_pkg::CFG_RST[1:0]};
			selHi_q <= 2'b00;
			cmd_q <= 8'h00;
			cmdStb_q <= 1'b0;
			irq_q <= 1'b0;
			initOk_q <= 1'b0;
			recon_per_q <= 40'h00_0000_0000;
		end
		else
		begin
			ri_q <= ri_d;
			por_q <= por_d;
			recon_q <= recon_d;
			tma_q <= tma_d;
			ta_q <= ta_d;
			diag_q <= diag_d;
			imr_q <= imr_d;
			ptrHi_q <= ptrHi_d;
			ptr_q <= ptr_d;
			ptrLoad_q <= ptrLoad_d;
			nextId_q <= nextId_d;
			node_q <= node_d;
			tent_q <= tent_d;
			link_q <= link_d;
			ext_q <= ext_d;
			cfgHi_q <= cfgHi_d;
			sel_q <= sel_d;
			selHi_q <= selHi_d;
			cmd_q <= cmd_d;
			cmdStb_q <= cmdStb_d;
			irq_q <= irq_d;
			initOk_q <= initOk_d;
			recon_per_q <= recon_per_d;
		end
	end

	// ==========================================================
	// Read side of the host bus
	tnr_pkg::tnr_bus_e bus_q, bus_d;
	logic [7:0] rdOut_q, rdOut_d;
	logic [7:0] rdMux;

	always_comb
	begin
		case (sAddr)
			tnr_pkg::ADR_STATUS: rdMux = statusVal;
			tnr_pkg::ADR_DIAG: rdMux = diag_q;
			tnr_pkg::ADR_PTR_HI: rdMux = ptrHi_q;
			tnr_pkg::ADR_PTR_LO: rdMux = ptr_q[7:0];
			tnr_pkg::ADR_SELIDX: rdMux = {selHi_q, 3'b000, sel_q};
			tnr_pkg::ADR_CFG: rdMux = {cfgHi_q, sel_q[1:0]};
			tnr_pkg::ADR_SHARED:
			begin
				case (tgt)
					tnr_pkg::SUB_TENT: rdMux = tent_q;
					tnr_pkg::SUB_NODE: rdMux = node_q;
					tnr_pkg::SUB_LINK: rdMux = link_q;
					tnr_pkg::SUB_NEXT: rdMux = nextId_q;
					default: rdMux = ext_q;
				endcase
			end
			// RAM data path lives outside this bank
			default: rdMux = 8'h00;
		endcase
		bus_d = bus_q;
		rdOut_d = rdOut_q;
		case (bus_q)
			tnr_pkg::BUS_IDLE:
			begin
				if (rdStart)
				begin
					bus_d = tnr_pkg::BUS_DRIVE;
					rdOut_d = rdMux;
				end
			end
			tnr_pkg::BUS_DRIVE:
			begin
				if (rdNow)
					bus_d = tnr_pkg::BUS_IDLE;
			end
			default: bus_d = tnr_pkg::BUS_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			bus_q <= tnr_pkg::BUS_IDLE;
			rdOut_q <= 8'h00;
			rdPrev_q <= 1'b1;
			wrPrev_q <= 1'b1;
		end
		else
		begin
			bus_q <= bus_d;
			rdOut_q <= rdOut_d;
			rdPrev_q <= rdNow;
			wrPrev_q <= wrNow;
		end
	end

	// ==========================================================
	// Outputs
	assign busDataOut = rdOut_q;
	assign busDataOe = bus_q == tnr_pkg::BUS_DRIVE;
	assign cmdCode = cmd_q;
	assign cmdStrobe = cmdStb_q;
	assign ramAddr = ptr_q;
	assign ramAddrLoad = ptrLoad_q;
	assign ramAutoInc = ptrHi_q[tnr_pkg::PH_AUTOINC];
	assign ramReadMode = ptrHi_q[tnr_pkg::PH_RDDATA];
	assign swReset = cfgHi_q[tnr_pkg::CFG_RESET];
	assign txEnable = cfgHi_q[tnr_pkg::CFG_TXEN];
	assign nodeId = node_q;
	assign tentId = tent_q;
	assign arbSlow = link_q[tnr_pkg::LK_ARB];
	assign clkPrescale = link_q[tnr_pkg::LK_CKP_HI:tnr_pkg::LK_CKP_LO];
	assign rcvAll = link_q[tnr_pkg::LK_RCVALL];
	assign fourNaks = link_q[tnr_pkg::LK_FOURNAK];
	assign pulseDriverOutput = link_q[tnr_pkg::LK_PMODE];
	assign fastReadControl = ext_q[tnr_pkg::EX_FASTRD];
	assign newTimingEnable = ext_q[tnr_pkg::EX_NEWTIM];
	assign initSeqAllowed = initOk_q;
	assign reconPeriodCyc = recon_per_q;
	assign nakOnRx = ri_q;
	assign irq = irq_q;

	// ==========================================================
	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	sequence sRdDiagQuiet;
		rdDiag && diagSetIn == 8'h00 && !cfgHi_q[tnr_pkg::CFG_RESET];
	endsequence
	sequence sWrPtrLo;
		wrTake && sAddr == tnr_pkg::ADR_PTR_LO;
	endsequence

	a_diag_read_clr: assert property (sRdDiagQuiet
		|=> (diag_q & tnr_pkg::DG_READ_CLR) == 8'h00)
		else $error("diagnostic flags survived a read");
	a_excess_nak_flag_keep: assert property (rdDiag && diag_q[tnr_pkg::DG_EXCESS_NAK_FLAG] && !clrExc
		&& !cfgHi_q[tnr_pkg::CFG_RESET] |=> diag_q[tnr_pkg::DG_EXCESS_NAK_FLAG])
		else $error("excess NAK flag lost on read");
	a_cmd_issue: assert property (wrCmd |=> cmdStrobe && cmdCode == $past(sData))
		else $error("command write not passed on");
	a_ptr_hi_hold: assert property (wrTake && sAddr == tnr_pkg::ADR_PTR_HI
		|=> $stable(ramAddr))
		else $error("pointer moved on high byte write");
	a_ptr_lo_load: assert property (sWrPtrLo |=> ramAddrLoad
		&& ramAddr == {$past(ptrHi_q[2:0]), $past(sData)})
		else $error("pointer not loaded by low byte");
	a_cfg_sel_clr: assert property (wrTake && sAddr == tnr_pkg::ADR_CFG
		|=> !sel_q[tnr_pkg::SEL_TWO] && sel_q[1:0] == $past(sData[1:0]))
		else $error("config write left select bits wrong");
	a_ext_read: assert property (rdStart && bus_q == tnr_pkg::BUS_IDLE
		&& sAddr == tnr_pkg::ADR_SHARED && sel_q[tnr_pkg::SEL_TWO]
		|=> busDataOe && busDataOut == $past(ext_q))
		else $error("select bit two did not reach extended setup");
	a_ri_set: assert property (evPacketStored |=> ri_q ##0 nakOnRx [*1])
		else $error("receiver inhibit not set after store");
	a_ri_hold: assert property (ri_q && !rxArm && !cfgHi_q[tnr_pkg::CFG_RESET] |=> ri_q)
		else $error("receiver inhibit dropped without arm");
	a_node_zero_por: assert property (wrNode && sData == 8'h00 |=> por_q)
		else $error("zero node ID did not flag reset");
	a_irq_combine: assert property (##1 irq == |($past(maskable) & $past(imr_q)))
		else $error("interrupt does not match masked status");
	a_next_read_clr: assert property (rdNext && !evNextIdUpdate
		&& !cfgHi_q[tnr_pkg::CFG_RESET] |=> !diag_q[tnr_pkg::DG_NEWNEXT])
		else $error("next-changed flag not cleared by read");
	a_swrst_keep: assert property (cfgHi_q[tnr_pkg::CFG_RESET] && !wrTake
		|=> $stable(link_q) && $stable(ext_q) && $stable(cfgHi_q))
		else $error("software reset disturbed setup");
	a_status_test: assert property (rdStart && bus_q == tnr_pkg::BUS_IDLE
		&& sAddr == tnr_pkg::ADR_STATUS |=> !busDataOut[3])
		else $error("test status bit read nonzero");

endmodule : tnr_register_bank
`default_nettype wire

// File: dv/tnr_host_model.sv
`default_nettype none
// ========
// Host bus master model
module tnr_host_model
(
	// Clock
	input wire logic clk,
	// Host bus pins
	output logic rdStrobe_b,
	output logic wrStrobe_b,
	output logic [2:0] busAddr,
	output logic [7:0] busDataIn,
	input wire logic [7:0] busDataOut,
	input wire logic busDataOe
);
	timeunit 1ns;
	timeprecision 1ps;

	initial
	begin
		rdStrobe_b = 1'b1;
		wrStrobe_b = 1'b1;
		busAddr = 3'h0;
		busDataIn = 8'h00;
	end

	// Address and data held past the trailing edge for the synchronisers
	task automatic write(input logic [2:0] a, input logic [7:0] d);
		@(negedge clk);
		busAddr = a;
		busDataIn = d;
		wrStrobe_b = 1'b0;
		repeat (4) @(negedge clk);
		wrStrobe_b = 1'b1;
		repeat (5) @(negedge clk);
		// Released bus shows the inverse, so a stale byte cannot pass
		busDataIn = ~d;
	endtask : write

	task automatic read(input logic [2:0] a, output logic [7:0] d, output logic ok);
		ok = 1'b0;
		d = 8'h00;
		@(negedge clk);
		// Address settles a cycle ahead so both synchronised copies agree
		busAddr = a;
		@(negedge clk);
		rdStrobe_b = 1'b0;
		for (int i = 0; i < 12 && !ok; i++)
		begin
			@(negedge clk);
			if (busDataOe === 1'b1)
			begin
				ok = 1'b1;
				d = busDataOut;
			end
		end
		@(negedge clk);
		rdStrobe_b = 1'b1;
		repeat (5) @(negedge clk);
		ok = ok & (busDataOe === 1'b0);
	endtask : read

endmodule : tnr_host_model
`default_nettype wire

// File: dv/token_net_host_register_bank_tb.sv
`default_nettype none
module token_net_host_register_bank_tb;
	timeunit 1ns;
	timeprecision 1ps;

	// ========
	// Signals
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic rdStrobe_b, wrStrobe_b, busDataOe, cmdStrobe, ramAddrLoad, ramAutoInc, ramReadMode;
	logic swReset, txEnable, arbSlow, rcvAll, fourNaks, pulseDriverOutput, fastReadControl;
	logic newTimingEnable, initSeqAllowed, nakOnRx, irq;
	logic lineIdle = 1'b0;
	logic [5:0] ev = 6'h00;
	logic [7:0] diagSetIn = 8'h00;
	logic [7:0] newNextId = 8'h00;
	logic [7:0] busDataIn, busDataOut, cmdCode, nodeId, tentId, c, u, v, h, l;
	logic [2:0] busAddr, clkPrescale;
	logic [10:0] ramAddr, a;
	logic [39:0] reconPeriodCyc;
	integer seed = 32'h17ec9325;
	int errCount = 0;
	int nTests = 0;
	int nCmd = 0;
	int nLoad = 0;

	always #12.5 clk = ~clk;

	// Counted mid-cycle, clear of the edge that launches the strobes
	always @(negedge clk)
	begin
		if (cmdStrobe === 1'b1) nCmd++;
		if (ramAddrLoad === 1'b1) nLoad++;
	end

	tnr_register_bank #(.RECON_CYC_00(32'h64), .RECON_CYC_01(32'h19), .RECON_CYC_10(32'h0c),
		.RECON_CYC_11(32'h06)) i_tnr_register_bank (.clk, .rst_b, .rdStrobe_b, .wrStrobe_b,
		.busAddr, .busDataIn, .busDataOut, .busDataOe, .evPacketStored(ev[0]), .evTxDone(ev[1]),
		.evTxAcked(ev[2]), .evRecon(ev[3]), .evExcessNak(ev[4]), .evNextIdUpdate(ev[5]),
		.newNextId, .diagSetIn, .lineIdle, .cmdCode, .cmdStrobe, .ramAddr, .ramAddrLoad,
		.ramAutoInc, .ramReadMode, .swReset, .txEnable, .nodeId, .tentId, .arbSlow, .clkPrescale,
		.rcvAll, .fourNaks, .pulseDriverOutput, .fastReadControl, .newTimingEnable,
		.initSeqAllowed, .reconPeriodCyc, .nakOnRx, .irq);

	tnr_host_model i_tnr_host_model (.clk, .rdStrobe_b, .wrStrobe_b, .busAddr, .busDataIn,
		.busDataOut, .busDataOe);

	// ========
	// Tasks
	task automatic giveVerdict();
		$display("Checks %0d, mismatches %0d", nTests, errCount);
		if (errCount == 0 && nTests > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : giveVerdict

	task automatic chkVal(input logic [39:0] got, input logic [39:0] exp);
		nTests++;
		if (got !== exp)
		begin
			errCount++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chkVal

	task automatic chkRd(input logic [2:0] adr, input logic [7:0] exp);
		logic [7:0] d;
		logic ok;
		i_tnr_host_model.read(adr, d, ok);
		if (ok !== 1'b1)
		begin
			errCount++;
			$display("Error at %0t: read handshake timed out", $time);
			giveVerdict();
		end
		else
			chkVal(40'(d), 40'(exp));
	endtask : chkRd

	task automatic wr(input logic [2:0] adr, input logic [7:0] d);
		i_tnr_host_model.write(adr, d);
	endtask : wr

	task automatic cmd(input logic [7:0] code);
		int k;
		k = nCmd;
		wr(3'h1, code);
		chkVal(40'(cmdCode), 40'(code));
		chkVal(40'(nCmd), 40'(k + 1));
	endtask : cmd

	// One-cycle event from the core, then a cycle for the flag to land
	task automatic pulse(input int b, input logic [7:0] d);
		@(negedge clk);
		ev[b] = 1'b1;
		diagSetIn = d;
		@(negedge clk);
		ev = 6'h00;
		diagSetIn = 8'h00;
		@(negedge clk);
	endtask : pulse

	task automatic doReset();
		@(negedge clk);
		rst_b = 1'b0;
		repeat (3) @(negedge clk);
		chkVal(40'({busDataOe, cmdStrobe, irq}), 40'h0);
		rst_b = 1'b1;
	endtask : doReset

	task automatic afterReset();
		chkRd(3'h0, tnr_pkg::STATUS_RST);
		chkRd(3'h1, tnr_pkg::DIAG_RST);
		chkRd(3'h6, tnr_pkg::CFG_RST);
		wr(3'h5, 8'h02);
		chkRd(3'h7, tnr_pkg::SETUP_RST);
		chkVal(40'(irq), 40'h0);
	endtask : afterReset

	function automatic logic [39:0] expPeriod(input logic [1:0] code, input logic [2:0] p);
		logic [39:0] b;
		case (code)
			2'b00: b = 40'h64;
			2'b01: b = 40'h19;
			2'b10: b = 40'h0c;
			default: b = 40'h06;
		endcase
		return b << p;
	endfunction : expPeriod

	// ========
	// Main sequence
	initial
	begin
		doReset();
		afterReset();
		$display("Test reset values done");
		h = 8'($random(seed)) & tnr_pkg::DG_READ_CLR;
		pulse(4, h);
		chkRd(3'h1, h | 8'h08);
		chkRd(3'h1, 8'h08);
		cmd(tnr_pkg::CMD_CLR_EXCESS_NAK_FLAG);
		chkRd(3'h1, 8'h00);
		newNextId = 8'($random(seed));
		pulse(5, 8'h00);
		chkRd(3'h1, 8'h02);
		wr(3'h5, 8'h03);
		wr(3'h7, ~newNextId);
		chkRd(3'h7, newNextId);
		chkRd(3'h1, 8'h00);
		chkRd(3'h4, 8'h00);
		$display("Test diagnostic flags done");
		pulse(3, 8'h00);
		chkRd(3'h0, 8'h95);
		cmd(tnr_pkg::CMD_CLR_FLAGS);
		chkRd(3'h0, 8'h81);
		wr(3'h0, 8'h80);
		chkVal(40'(irq), 40'h1);
		cmd(8'h04);
		chkRd(3'h0, 8'h01);
		chkVal(40'({irq, nakOnRx}), 40'h0);
		pulse(0, 8'h00);
		chkVal(40'({irq, nakOnRx}), 40'h3);
		wr(3'h0, 8'h00);
		chkVal(40'(irq), 40'h0);
		cmd(8'h04);
		cmd(8'h03);
		chkRd(3'h0, 8'h00);
		pulse(2, 8'h00);
		pulse(1, 8'h00);
		chkRd(3'h0, 8'h03);
		$display("Test status done");
		for (int i = 0; i < 3; i++)
		begin
			h = 8'($random(seed)) & 8'hc7;
			l = 8'($random(seed));
			a = ramAddr;
			wr(3'h2, h);
			chkVal(40'({nLoad, ramAddr}), 40'({i, a}));
			wr(3'h3, l);
			chkVal(40'({nLoad, ramAddr}), 40'({i + 1, h[2:0], l}));
			chkVal(40'({ramReadMode, ramAutoInc}), 40'(h[7:6]));
		end
		$display("Test pointer done");
		c = 8'($random(seed)) & 8'h3f;
		// Undefined setup bits are written as zero
		v = 8'($random(seed)) & 8'h8f;
		u = 8'($random(seed)) & 8'hdf;
		wr(3'h5, 8'hc4);
		wr(3'h7, v);
		chkRd(3'h7, v & 8'h8f);
		chkVal(40'({fastReadControl, newTimingEnable}), 40'({v[7], v[3]}));
		wr(3'h6, c);
		chkRd(3'h6, c);
		chkVal(40'(txEnable), 40'(c[5]));
		chkRd(3'h5, {6'h30, c[1:0]});
		wr(3'h5, 8'h02);
		chkRd(3'h6, {c[7:2], 2'b10});
		wr(3'h7, u);
		chkRd(3'h7, u & 8'hdf);
		chkVal(40'({pulseDriverOutput, fourNaks, rcvAll, clkPrescale, arbSlow}),
			40'({u[7:6], u[4:0]}));
		wr(3'h5, 8'h00);
		wr(3'h7, l);
		chkRd(3'h7, l);
		wr(3'h5, 8'h01);
		wr(3'h7, ~l);
		chkVal(40'({tentId, nodeId}), 40'({l, ~l}));
		wr(3'h7, 8'h00);
		chkRd(3'h0, 8'h13);
		$display("Test sub-address done");
		wr(3'h5, 8'h04);
		for (int i = 0; i < 4; i++)
		begin
			lineIdle = i[0];
			wr(3'h7, {5'h00, i[1], i[1:0]});
			chkVal(reconPeriodCyc, expPeriod(i[1:0], u[3:1]));
			chkVal(40'(initSeqAllowed), 40'(i[1] | i[0]));
		end
		$display("Test recon period done");
		pulse(4, 8'hf4);
		wr(3'h6, c | 8'h80);
		chkVal(40'(swReset), 40'h1);
		wr(3'h6, c);
		chkRd(3'h0, tnr_pkg::STATUS_RST);
		chkRd(3'h1, 8'h00);
		chkRd(3'h6, c);
		wr(3'h5, 8'h02);
		chkRd(3'h7, u & 8'hdf);
		$display("Test software reset done");
		doReset();
		afterReset();
		$display("Test hardware reset done");
		giveVerdict();
	end

endmodule : token_net_host_register_bank_tb
`default_nettype wire
